// *** hw/pdt_top.sv ***
/*
  Prescaled down-timer group: timers X, Y and 1, each behind its own
  8-bit prescaler, with mode register, request and enable registers.
  Assumes a plain strobe register port on CORE_CLK, pins that are
  asynchronous to it, and a slow sub-oscillator input level.
*/
// Behaviour
// - A stage loaded with n divides its input ticks by n plus one.
// - Each counter steps down by one on every active input tick.
// - A timer at 255 underflows and flags after 256 ticks.
// - In width mode timer X counts only while counter_pin_a is high.
// - In width mode X underflow and the end of the high level both request.
// - The internal source of the X prescaler is the core clock over 16.
// - Each timer has a stop bit; one halts it, zero lets it count.
// - In event mode timer Y counts counter_pin_b edges of a chosen polarity.
// - Underflow sets the request flag; only enabled flags interrupt.
// - In pulse mode timer X drives a square wave on counter_pin_a.
// - Prescaler 63 and timer 1 at 7 give a request every 8192 core clocks, about 32.8 us.
// - On underflow a counter reloads itself from its latch.
// - In pulse mode the pin level inverts on every timer underflow.
// - Y source select one takes the sub-oscillator; at zero the low-speed bit picks sub-oscillator over 16, else clock over 16.
`timescale 1ns/1ps
`default_nettype none

module pdt_top
  import pdt_pkg::*;
(
  // Clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       RST,
  // Register port
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // Interrupt
  output logic            IRQ,
  // Counter pin A
  input  wire logic       CNTR_A_IN,
  output logic            CNTR_A_OUT,
  output logic            CNTR_A_OE,
  // Counter pin B
  input  wire logic       CNTR_B_IN,
  output logic            CNTR_B_OUT,
  output logic            CNTR_B_OE,
  // Sub-oscillator
  input  wire logic       SUB_OSC_IN
);

  typedef struct packed {
    logic [3:0] div16;
    logic [3:0] sub_div;
    logic       a_prev;
    logic       b_prev;
    logic       sub_prev;
    logic [7:0] mode;
    logic [2:0] aux;
    logic [2:0] req;
    logic [2:0] ena;
    logic       pa_req;
    logic       pa_ena;
    logic       a_lvl;
    logic       b_lvl;
    logic       a_oe;
    logic       b_oe;
    logic [7:0] rdata;
    logic       irq;
  } pdt_core_t;

  pdt_core_t st;
  pdt_core_t next_st;

  logic [2:0]            pin_s;
  logic                  a_lvl_s;
  logic                  b_lvl_s;
  logic                  a_rise;
  logic                  a_fall;
  logic                  b_rise;
  logic                  b_fall;
  logic                  sub_rise;
  logic                  a_edge;
  logic                  b_edge;
  logic                  div_tick;
  logic                  sub16_tick;
  logic                  y_timer_src;
  logic [1:0]            x_mode;
  logic [1:0]            y_mode;
  logic                  prescaler_x_count_in;
  logic                  prescaler_y_count_in;
  logic [PDT_STAGES-1:0] stage_in;
  logic [PDT_STAGES-1:0] stage_stop;
  logic [PDT_STAGES-1:0] stage_wr;
  logic [PDT_STAGES-1:0] stage_uf;
  logic [7:0]            stage_cnt [PDT_STAGES];
  logic [2:0]            req_set;
  logic [2:0]            req_clr;
  logic                  pa_set;
  logic [7:0]            rd_mux;

  // Pins are asynchronous, so every one passes two flops first
  pdt_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk  (CORE_CLK),
    .rst  (RST),
    .din  ({SUB_OSC_IN, CNTR_B_IN, CNTR_A_IN}),
    .dout (pin_s)
  );

  assign a_lvl_s = pin_s[0];
  assign b_lvl_s = pin_s[1];

  // Edges from the settled level against its last sample
  assign a_rise   = a_lvl_s & ~st.a_prev;
  assign a_fall   = ~a_lvl_s & st.a_prev;
  assign b_rise   = b_lvl_s & ~st.b_prev;
  assign b_fall   = ~b_lvl_s & st.b_prev;
  assign sub_rise = pin_s[2] & ~st.sub_prev;

  // Edge bit set picks the falling edge
  assign a_edge = st.mode[PDT_X_EDGE] ? a_fall : a_rise;
  assign b_edge = st.mode[PDT_Y_EDGE] ? b_fall : b_rise;

  // Internal sources: one tick in sixteen core clocks, or in sixteen sub-oscillator rises
  assign div_tick   = (st.div16 == PDT_DIV_LAST);
  assign sub16_tick = sub_rise & (st.sub_div == PDT_DIV_LAST);

  assign x_mode = st.mode[PDT_X_MODE_LO +: 2];
  assign y_mode = st.mode[PDT_Y_MODE_LO +: 2];

  // Timer X source: pin edges in event mode, gated clock in width mode
  always_comb begin
    if (x_mode == PDT_M_EVENT) begin
      prescaler_x_count_in = a_edge;
    end else if (x_mode == PDT_M_WIDTH) begin
      prescaler_x_count_in = div_tick & a_lvl_s;
    end else begin
      prescaler_x_count_in = div_tick;
    end
  end

  // Switching the Y source can emit a short extra tick, so software
  // must select it before loading the Y stages
  always_comb begin
    if (st.aux[PDT_Y_SRC_SUB]) begin
      y_timer_src = sub_rise;
    end else if (st.aux[PDT_LOW_SPEED]) begin
      y_timer_src = sub16_tick;
    end else begin
      y_timer_src = div_tick;
    end
  end

  // Timer Y source by mode
  always_comb begin
    if (y_mode == PDT_M_EVENT) begin
      prescaler_y_count_in = b_edge;
    end else if (y_mode == PDT_M_WIDTH) begin
      prescaler_y_count_in = y_timer_src & b_lvl_s;
    end else begin
      prescaler_y_count_in = y_timer_src;
    end
  end

  // Each timer runs off its own prescaler underflow
  assign stage_in[PDT_ST_PRESCALER_X_COUNT]  = prescaler_x_count_in;
  assign stage_in[PDT_ST_TX]    = stage_uf[PDT_ST_PRESCALER_X_COUNT];
  assign stage_in[PDT_ST_PRESCALER_Y_COUNT]  = prescaler_y_count_in;
  assign stage_in[PDT_ST_TY]    = stage_uf[PDT_ST_PRESCALER_Y_COUNT];
  assign stage_in[PDT_ST_PRESCALER_TWELVE] = div_tick;
  assign stage_in[PDT_ST_T1]    = stage_uf[PDT_ST_PRESCALER_TWELVE];

  // Stop bits halt prescaler and timer together
  assign stage_stop[PDT_ST_PRESCALER_X_COUNT]  = st.mode[PDT_X_STOP];
  assign stage_stop[PDT_ST_TX]    = st.mode[PDT_X_STOP];
  assign stage_stop[PDT_ST_PRESCALER_Y_COUNT]  = st.mode[PDT_Y_STOP];
  assign stage_stop[PDT_ST_TY]    = st.mode[PDT_Y_STOP];
  assign stage_stop[PDT_ST_PRESCALER_TWELVE] = st.aux[PDT_T1_STOP];
  assign stage_stop[PDT_ST_T1]    = st.aux[PDT_T1_STOP];

  // All six counter stages share one implementation
  for (genvar g = 0; g < PDT_STAGES; g++) begin : g_stage
    assign stage_wr[g] = WR && (ADDR == PDT_STAGE_ADDR[g]);

    pdt_stage #(
      .WIDTH (8)
    ) u_stage (
      .clk   (CORE_CLK),
      .rst   (RST),
      .tick  (stage_in[g]),
      .stop  (stage_stop[g]),
      .load  (stage_wr[g]),
      .wdata (WDATA),
      .count (stage_cnt[g]),
      .uflow (stage_uf[g])
    );
  end

  // Hardware events for the request flags
  assign req_set[0] = stage_uf[PDT_ST_TX];
  assign req_set[1] = stage_uf[PDT_ST_TY];
  assign req_set[2] = stage_uf[PDT_ST_T1];
  assign pa_set     = a_fall && (x_mode == PDT_M_WIDTH);

  // Write one clears a request flag
  always_comb begin
    req_clr = 3'h0;
    if (WR && ADDR == PDT_IRQ_REQUEST) begin
      req_clr = WDATA[PDT_IRQ_X_BIT +: 3];
    end
  end

  // Read multiplexer; unmapped offsets read as zero
  always_comb begin
    rd_mux = 8'h00;
    for (int i = 0; i < PDT_STAGES; i++) begin
      if (ADDR == PDT_STAGE_ADDR[i]) begin
        rd_mux = stage_cnt[i];
      end
    end
    case (ADDR)
      PDT_TIMER_XY_MODE: begin
        rd_mux = st.mode;
      end
      PDT_AUX_CONTROL: begin
        rd_mux = {5'h00, st.aux};
      end
      PDT_PIN_A_STATUS: begin
        rd_mux = {6'h00, st.pa_ena, st.pa_req};
      end
      PDT_IRQ_REQUEST: begin
        rd_mux = {1'b0, st.req, 4'h0};
      end
      PDT_IRQ_ENABLE: begin
        rd_mux = {1'b0, st.ena, 4'h0};
      end
      default: begin
        rd_mux = rd_mux;
      end
    endcase
  end

  // Next state of the core
  always_comb begin
    next_st          = st;
    next_st.div16    = st.div16 + 4'h1;
    next_st.a_prev   = a_lvl_s;
    next_st.b_prev   = b_lvl_s;
    next_st.sub_prev = pin_s[2];
    if (sub_rise) begin
      next_st.sub_div = st.sub_div + 4'h1;
    end

    // Control register writes
    if (WR) begin
      case (ADDR)
        PDT_TIMER_XY_MODE: begin
          next_st.mode = WDATA;
        end
        PDT_AUX_CONTROL: begin
          next_st.aux = WDATA[2:0];
        end
        PDT_IRQ_ENABLE: begin
          next_st.ena = WDATA[PDT_IRQ_X_BIT +: 3];
        end
        PDT_PIN_A_STATUS: begin
          next_st.pa_ena = WDATA[PDT_PA_ENA_BIT];
        end
        default: begin
          next_st.mode = next_st.mode;
        end
      endcase
    end

    // Set beats clear so a same-cycle event is kept
    next_st.req = (st.req & ~req_clr) | req_set;
    next_st.pa_req = st.pa_req;
    if (WR && ADDR == PDT_PIN_A_STATUS && WDATA[PDT_PA_REQ_BIT]) begin
      next_st.pa_req = 1'b0;
    end
    if (pa_set) begin
      next_st.pa_req = 1'b1;
    end

    // Pins idle high; in pulse mode they toggle at each underflow
    if (x_mode != PDT_M_PULSE) begin
      next_st.a_lvl = 1'b1;
    end else if (stage_uf[PDT_ST_TX]) begin
      next_st.a_lvl = ~st.a_lvl;
    end
    if (y_mode != PDT_M_PULSE) begin
      next_st.b_lvl = 1'b1;
    end else if (stage_uf[PDT_ST_TY]) begin
      next_st.b_lvl = ~st.b_lvl;
    end
    next_st.a_oe = (next_st.mode[PDT_X_MODE_LO +: 2] == PDT_M_PULSE);
    next_st.b_oe = (next_st.mode[PDT_Y_MODE_LO +: 2] == PDT_M_PULSE);

    // Read data stands one cycle only
    next_st.rdata = RD ? rd_mux : 8'h00;

    // Level interrupt from any enabled flag
    next_st.irq = |(next_st.req & next_st.ena) | (next_st.pa_req & next_st.pa_ena);
  end

  // State register; edge history starts low like the synchroniser, so a
  // pin that idles high shows one rising edge after reset, harmless while
  // the modes still hold their timer value
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      st       <= '0;
      st.mode  <= PDT_MODE_RESET;
      st.aux   <= PDT_AUX_RESET;
      st.a_lvl <= 1'b1;
      st.b_lvl <= 1'b1;
      st.a_prev <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign RDATA      = st.rdata;
  assign IRQ        = st.irq;
  assign CNTR_A_OUT = st.a_lvl;
  assign CNTR_A_OE  = st.a_oe;
  assign CNTR_B_OUT = st.b_lvl;
  assign CNTR_B_OE  = st.b_oe;

endmodule : pdt_top

`default_nettype wire

// *** inc/pdt_pkg.sv ***
/*
  Constants for the prescaled down-timer group: register offsets,
  field positions, reset values and the internal source divider.
  Assumes byte-wide registers on a plain strobe port, one clock domain.
*/
package pdt_pkg;

  // Clock of the block
  localparam int          PDT_CLK_PERIOD_NS = 4;
  localparam int          PDT_SRC_DIV       = 16;
  localparam logic [3:0]  PDT_DIV_LAST      = 4'(PDT_SRC_DIV - 1);

  // Register offsets
  localparam logic [7:0]  PDT_PRESCALER_TWELVE = 8'h20;
  localparam logic [7:0]  PDT_TIMER_ONE_COUNT  = 8'h21;
  localparam logic [7:0]  PDT_TIMER_XY_MODE    = 8'h23;
  localparam logic [7:0]  PDT_PRESCALER_X      = 8'h24;
  localparam logic [7:0]  PDT_TIMER_X          = 8'h25;
  localparam logic [7:0]  PDT_PRESCALER_Y      = 8'h26;
  localparam logic [7:0]  PDT_TIMER_Y          = 8'h27;
  localparam logic [7:0]  PDT_AUX_CONTROL      = 8'h28;
  localparam logic [7:0]  PDT_PIN_A_STATUS     = 8'h29;
  localparam logic [7:0]  PDT_IRQ_REQUEST      = 8'h3C;
  localparam logic [7:0]  PDT_IRQ_ENABLE       = 8'h3E;

  // Counter stages: index into the stage array
  localparam int PDT_ST_PRESCALER_X_COUNT  = 0;
  localparam int PDT_ST_TX    = 1;
  localparam int PDT_ST_PRESCALER_Y_COUNT  = 2;
  localparam int PDT_ST_TY    = 3;
  localparam int PDT_ST_PRESCALER_TWELVE = 4;
  localparam int PDT_ST_T1    = 5;
  localparam int PDT_STAGES   = 6;
  localparam logic [5:0][7:0] PDT_STAGE_ADDR = {
    PDT_TIMER_ONE_COUNT, PDT_PRESCALER_TWELVE, PDT_TIMER_Y,
    PDT_PRESCALER_Y, PDT_TIMER_X, PDT_PRESCALER_X};
  localparam logic [7:0]  PDT_STAGE_RESET = 8'hFF;

  // Fields of timer_xy_mode
  localparam int PDT_X_MODE_LO = 0;
  localparam int PDT_X_EDGE    = 2;
  localparam int PDT_X_STOP    = 3;
  localparam int PDT_Y_MODE_LO = 4;
  localparam int PDT_Y_EDGE    = 6;
  localparam int PDT_Y_STOP    = 7;
  localparam logic [7:0] PDT_MODE_RESET = 8'h00;

  // Operating modes of timers X and Y
  typedef enum logic [1:0] {
    PDT_M_TIMER = 2'b00,
    PDT_M_PULSE = 2'b01,
    PDT_M_EVENT = 2'b10,
    PDT_M_WIDTH = 2'b11
  } pdt_mode_t;

  // Fields of the auxiliary control register
  localparam int PDT_T1_STOP   = 0;
  localparam int PDT_Y_SRC_SUB = 1;
  localparam int PDT_LOW_SPEED = 2;
  localparam logic [2:0] PDT_AUX_RESET = 3'h0;

  // Fields of the request and enable registers
  localparam int PDT_IRQ_X_BIT  = 4;
  localparam int PDT_IRQ_Y_BIT  = 5;
  localparam int PDT_IRQ_T1_BIT = 6;
  localparam int PDT_PA_REQ_BIT = 0;
  localparam int PDT_PA_ENA_BIT = 1;

endpackage : pdt_pkg

// *** hw/pdt_sync.sv ***
/*
  Two-flop synchroniser for a group of pin levels.
  Assumes each bit is an independent slow level from outside the clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pdt_sync
  import pdt_pkg::*;
#(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Levels
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } pdt_sync_t;

  pdt_sync_t st;
  pdt_sync_t next_st;

  // First stage feeds only the second
  always_comb begin
    next_st        = st;
    next_st.meta   = din;
    next_st.stable = st.meta;
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.stable;

endmodule : pdt_sync

`default_nettype wire

// *** hw/pdt_stage.sv ***
/*
  One reloading 8-bit down-counter with latch, used for every
  prescaler and timer. Assumes tick and load are same-clock pulses.
*/
`timescale 1ns/1ps
`default_nettype none

module pdt_stage
  import pdt_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Count control
  input  wire logic             tick,
  input  wire logic             stop,
  // Software write
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] wdata,
  // State out
  output logic      [WIDTH-1:0] count,
  output logic                  uflow
);

  typedef struct packed {
    logic [WIDTH-1:0] latch;
    logic [WIDTH-1:0] count;
  } pdt_stage_t;

  pdt_stage_t st;
  pdt_stage_t next_st;

  // Zero reached on an active tick; chained stage sees it same cycle
  assign uflow = tick & ~stop & (st.count == '0);

  // Load, decrement and reload
  always_comb begin
    next_st = st;
    if (tick && !stop) begin
      if (uflow) begin
        next_st.count = st.latch;
      end else begin
        next_st.count = st.count - 1'b1;
      end
    end
    if (load) begin
      next_st.latch = wdata;
      if (stop) begin
        next_st.count = wdata;
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= {WIDTH'(PDT_STAGE_RESET), WIDTH'(PDT_STAGE_RESET)};
    end else begin
      st <= next_st;
    end
  end

  assign count = st.count;

endmodule : pdt_stage

`default_nettype wire

// *** bench/pdt_chk_asserts.sv ***
/* Port checker for the prescaled down-timer group.
   Assumes it is bound to pdt_top and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none

module pdt_chk
  import pdt_pkg::*;
(
  // Clock, reset and register port
  input  wire logic       CORE_CLK,
  input  wire logic       RST,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  input  wire logic [7:0] RDATA,
  input  wire logic       IRQ,
  // Counter pins and sub-oscillator
  input  wire logic       CNTR_A_IN,
  input  wire logic       CNTR_A_OUT,
  input  wire logic       CNTR_A_OE,
  input  wire logic       CNTR_B_IN,
  input  wire logic       CNTR_B_OUT,
  input  wire logic       CNTR_B_OE,
  input  wire logic       SUB_OSC_IN
);
  typedef struct packed {
    logic [7:0] mode;
    logic [3:0] en;
  } pdt_shadow_t;

  pdt_shadow_t st;
  pdt_shadow_t next_st;
  logic [1:0]  xmode;
  logic [1:0]  ymode;
  logic        en_any;

  // Shadow of mode and enables, rebuilt from bus writes only
  always_comb begin
    next_st = st;
    if (WR && ADDR == PDT_TIMER_XY_MODE) next_st.mode = WDATA;
    if (WR && ADDR == PDT_IRQ_ENABLE) next_st.en[2:0] = WDATA[6:4];
    if (WR && ADDR == PDT_PIN_A_STATUS) next_st.en[3] = WDATA[PDT_PA_ENA_BIT];
  end

  // Shadow register, cleared with the design
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) st <= '0;
    else st <= next_st;
  end

  // Field views for the properties
  assign xmode  = st.mode[1:0];
  assign ymode  = st.mode[5:4];
  assign en_any = |st.en;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  sequence rd_hole_s;
    RD && ADDR == 8'h22;
  endsequence

  sequence rd_req_s;
    RD && ADDR == PDT_IRQ_REQUEST;
  endsequence

  // Read data only in the cycle after a read strobe
  rdata_quiet_a: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data not zero outside a read answer");
  hole_zero_a: assert property (rd_hole_s |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  req_unused_a: assert property (rd_req_s |=> RDATA[7] == 1'h0 && RDATA[3:0] == 4'h0)
    else $error("absent request bits read as one");
  // Interrupt level needs an enable and holds until a write
  irq_needs_en_a: assert property (IRQ |-> en_any)
    else $error("interrupt raised with all enables off");
  irq_sticky_a: assert property (IRQ && !WR |=> IRQ)
    else $error("interrupt dropped without a write");
  // Drive enables follow pulse mode once the mode is settled
  oe_a_mode_a: assert property (xmode == $past(xmode) |-> CNTR_A_OE == (xmode == 2'h1))
    else $error("pin a drive does not follow timer x mode");
  oe_b_mode_a: assert property (ymode == $past(ymode) |-> CNTR_B_OE == (ymode == 2'h1))
    else $error("pin b drive does not follow timer y mode");
  pin_idle_a: assert property (xmode != 2'h1 && $past(xmode) != 2'h1 |-> CNTR_A_OUT)
    else $error("pin a not high outside pulse mode");
  pin_b_idle_a: assert property (ymode != 2'h1 && $past(ymode) != 2'h1 |-> CNTR_B_OUT)
    else $error("pin b not high outside pulse mode");
endmodule : pdt_chk

bind pdt_top pdt_chk u_chk (.CORE_CLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .IRQ, .CNTR_A_IN,
  .CNTR_A_OUT, .CNTR_A_OE, .CNTR_B_IN, .CNTR_B_OUT, .CNTR_B_OE, .SUB_OSC_IN);

`default_nettype wire

// *** bench/pdt_pin_src.sv ***
/* Pulse source on the counter pins: pin B bursts, one pin A high level.
   Assumes the bench gives the pin to the design while it drives. */
`timescale 1ns/1ps
`default_nettype none

module pdt_pin_src
  import pdt_pkg::*;
(
  // Clock and request
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [7:0] edges,
  input  wire logic [3:0] half,
  input  wire logic [9:0] high_len,
  // Pin levels and status
  output logic            pin_a,
  output logic            pin_b,
  output logic            busy
);
  // One request at a time; half sets a fast or a slow pace
  initial begin
    pin_a = 1'h0;
    pin_b = 1'h1;
    busy  = 1'h0;
    forever begin
      @(posedge clk);
      if (go) begin
        busy <= 1'h1;
        repeat (edges) begin
          repeat (half) @(posedge clk);
          pin_b <= 1'h0;
          repeat (half) @(posedge clk);
          pin_b <= 1'h1;
        end
        if (high_len != 10'h000) begin
          pin_a <= 1'h1;
          repeat (high_len) @(posedge clk);
          pin_a <= 1'h0;
        end
        busy <= 1'h0;
      end
    end
  end
endmodule : pdt_pin_src

`default_nettype wire

// *** bench/testbench.sv ***
/* Self-checking bench for pdt_top, one task per scenario.
   Assumes the pulse source model and the bound port checker. */
`timescale 1ns/1ps
`default_nettype none

module testbench
  import pdt_pkg::*;
;
  logic       core_clk = 1'h0;
  logic       rst = 1'h1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'h0;
  logic       rd = 1'h0;
  logic [7:0] rdata;
  logic       irq, a_out, a_oe, b_out, b_oe, src_a, src_b, busy;
  logic       go = 1'h0;
  logic       sub_osc = 1'h0;
  logic [7:0] edges = 8'h00;
  logic [3:0] half = 4'h1;
  logic [9:0] high_len = 10'h000;
  int         mismatches = 0;
  int         checks_done = 0;
  int         cyc = 0;

  // Clock and cycle count
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  // A pin reads the design's drive while enabled, else the source
  pdt_top DUT (.CORE_CLK(core_clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .IRQ(irq), .CNTR_A_IN(a_oe ? a_out : src_a), .CNTR_A_OUT(a_out), .CNTR_A_OE(a_oe),
    .CNTR_B_IN(b_oe ? b_out : src_b), .CNTR_B_OUT(b_out), .CNTR_B_OE(b_oe), .SUB_OSC_IN(sub_osc));
  pdt_pin_src u_src (.clk(core_clk), .go(go), .edges(edges), .half(half), .high_len(high_len),
    .pin_a(src_a), .pin_b(src_b), .busy(busy));

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge core_clk);
    wr    <= 1'h0;
  endtask : wr_reg

  // Read data stands only in the cycle after the strobe
  task automatic expect_reg(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    addr <= a;
    rd   <= 1'h1;
    @(posedge core_clk);
    rd   <= 1'h0;
    #1 check(what, {8'h00, exp}, {8'h00, rdata});
  endtask : expect_reg

  task automatic pulses(input logic [7:0] e, input logic [3:0] h, input logic [9:0] len);
    int n;
    @(posedge core_clk);
    edges    <= e;
    half     <= h;
    high_len <= len;
    go       <= 1'h1;
    @(posedge core_clk);
    go       <= 1'h0;
    @(posedge core_clk);
    n = 0;
    while (busy === 1'h1 && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
  endtask : pulses

  // Waits for a fresh rising edge of the interrupt
  task automatic wait_irq(output int c);
    int n;
    n = 0;
    while (irq === 1'h1 && n < 9999) begin
      @(posedge core_clk);
      n++;
    end
    while (irq !== 1'h1 && n < 9999) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 9999) check("irq wait", 16'h0001, 16'h0000);
    c = cyc;
  endtask : wait_irq

  task automatic wait_out(output int c);
    logic v;
    int   n;
    v = a_out;
    n = 0;
    while (a_out === v && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    c = cyc;
  endtask : wait_out

  // Enable first, then clear, so the stale flag cannot fake a start
  task automatic irq_period(input string what, input logic [7:0] en, input int exp);
    int c0, c1;
    wr_reg(PDT_IRQ_ENABLE, en);
    wr_reg(PDT_IRQ_REQUEST, en);
    wait_irq(c0);
    wr_reg(PDT_IRQ_REQUEST, en);
    wait_irq(c1);
    check(what, 16'(exp), 16'(c1 - c0));
    wr_reg(PDT_IRQ_ENABLE, 8'h00);
  endtask : irq_period

  task automatic s_reset;
    expect_reg("mode", PDT_TIMER_XY_MODE, PDT_MODE_RESET);
    expect_reg("timer x", PDT_TIMER_X, PDT_STAGE_RESET);
    expect_reg("request", PDT_IRQ_REQUEST, 8'h00);
    expect_reg("hole", 8'h22, 8'h00);
    wr_reg(PDT_IRQ_ENABLE, 8'h70);
    expect_reg("enable", PDT_IRQ_ENABLE, 8'h70);
    wr_reg(PDT_IRQ_ENABLE, 8'h00);
  endtask : s_reset

  task automatic s_divide;
    logic [7:0] p [2] = '{8'h03, 8'h00};
    logic [7:0] t [2] = '{8'h05, 8'hFF};
    for (int i = 0; i < 2; i++) begin
      wr_reg(PDT_TIMER_XY_MODE, 8'h08);
      wr_reg(PDT_PRESCALER_X, p[i]);
      wr_reg(PDT_TIMER_X, t[i]);
      expect_reg("x loaded", PDT_TIMER_X, t[i]);
      repeat (80) @(posedge core_clk);
      expect_reg("x held", PDT_TIMER_X, t[i]);
      wr_reg(PDT_TIMER_XY_MODE, 8'h00);
      irq_period("x period", 8'h10, PDT_SRC_DIV * (p[i] + 1) * (t[i] + 1));
    end
    wr_reg(PDT_IRQ_REQUEST, 8'h10);
    repeat (4200) @(posedge core_clk);
    expect_reg("x flag", PDT_IRQ_REQUEST, 8'h10);
    check("masked irq", 16'h0000, 16'(irq));
  endtask : s_divide

  task automatic s_pulse;
    int c0, c1;
    wr_reg(PDT_TIMER_XY_MODE, 8'h08);
    wr_reg(PDT_PRESCALER_X, 8'h00);
    wr_reg(PDT_TIMER_X, 8'h01);
    wr_reg(PDT_TIMER_XY_MODE, 8'h11);
    wait_out(c0);
    wait_out(c1);
    check("pin a toggle", 16'(2 * PDT_SRC_DIV), 16'(c1 - c0));
    check("pin a drive", 16'h0001, 16'(a_oe));
    check("pin b drive", 16'h0001, 16'(b_oe));
    wr_reg(PDT_TIMER_XY_MODE, 8'h00);
    repeat (3) @(posedge core_clk);
    check("pin a idle", 16'h0001, 16'({a_oe, a_out}));
    check("pin b idle", 16'h0001, 16'({b_oe, b_out}));
  endtask : s_pulse

  task automatic s_event;
    wr_reg(PDT_AUX_CONTROL, 8'h00);
    wr_reg(PDT_TIMER_XY_MODE, 8'hE0);
    wr_reg(PDT_PRESCALER_Y, 8'h00);
    wr_reg(PDT_TIMER_Y, 8'hFF);
    wr_reg(PDT_TIMER_XY_MODE, 8'h60);
    pulses(8'h03, 4'h3, 10'h000);
    pulses(8'h02, 4'h9, 10'h000);
    repeat (6) @(posedge core_clk);
    expect_reg("y events", PDT_TIMER_Y, 8'hFA);
    wr_reg(PDT_TIMER_XY_MODE, 8'h20);
    pulses(8'h02, 4'h3, 10'h000);
    repeat (6) @(posedge core_clk);
    expect_reg("y rising events", PDT_TIMER_Y, 8'hF8);
  endtask : s_event

  task automatic s_width;
    wr_reg(PDT_TIMER_XY_MODE, 8'h0B);
    wr_reg(PDT_PRESCALER_X, 8'h00);
    wr_reg(PDT_TIMER_X, 8'hFF);
    wr_reg(PDT_PIN_A_STATUS, 8'h03);
    wr_reg(PDT_TIMER_XY_MODE, 8'h03);
    repeat (100) @(posedge core_clk);
    expect_reg("x low level", PDT_TIMER_X, 8'hFF);
    pulses(8'h00, 4'h1, 10'h0A0);
    repeat (6) @(posedge core_clk);
    expect_reg("x high width", PDT_TIMER_X, 8'hF5);
    expect_reg("pin a request", PDT_PIN_A_STATUS, 8'h03);
    check("pin a irq", 16'h0001, 16'(irq));
    wr_reg(PDT_PIN_A_STATUS, 8'h01);
  endtask : s_width

  // Direct sub-oscillator edges, then the same source over 16
  task automatic s_sub;
    logic [7:0] src [2] = '{8'h02, 8'h04};
    logic [7:0] exp [2] = '{8'hFA, 8'hFD};
    for (int i = 0; i < 2; i++) begin
      wr_reg(PDT_TIMER_XY_MODE, 8'h83);
      wr_reg(PDT_AUX_CONTROL, src[i]);
      wr_reg(PDT_PRESCALER_Y, 8'h00);
      wr_reg(PDT_TIMER_Y, 8'hFF);
      wr_reg(PDT_TIMER_XY_MODE, 8'h03);
      repeat (i * 27 + 5) begin
        repeat (3) @(posedge core_clk);
        sub_osc <= 1'h1;
        repeat (3) @(posedge core_clk);
        sub_osc <= 1'h0;
      end
      repeat (6) @(posedge core_clk);
      expect_reg("y sub source", PDT_TIMER_Y, exp[i]);
    end
    wr_reg(PDT_AUX_CONTROL, 8'h00);
  endtask : s_sub

  task automatic s_timer1;
    wr_reg(PDT_AUX_CONTROL, 8'h01);
    wr_reg(PDT_PRESCALER_TWELVE, 8'h3F);
    wr_reg(PDT_TIMER_ONE_COUNT, 8'h07);
    wr_reg(PDT_AUX_CONTROL, 8'h00);
    irq_period("timer one period", 8'h40, PDT_SRC_DIV * 64 * 8);
  endtask : s_timer1

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  // Main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'h0;
    s_reset();
    s_divide();
    s_pulse();
    s_event();
    s_width();
    s_sub();
    s_timer1();
    final_report();
  end

  // Watchdog, about twice the expected run
  initial begin
    repeat (60000) @(posedge core_clk);
    mismatches++;
    final_report();
  end
endmodule : testbench

`default_nettype wire
